// file: rtl/sas_params.svh
// Purpose: offsets, field positions, reset values of the accumulate/shift block
// Assumes: byte addresses on a 32-bit AXI4-Lite slave, one word per register
// Notes: included by the package, the bus slave, the accumulate/shift module and the testbench
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
`define SAS_ADDR_W 8
`define SAS_CTRL_OFS 8'h00
`define SAS_RES3_OFS 8'h04
`define SAS_RES2_OFS 8'h08
`define SAS_RES1_OFS 8'h0c
`define SAS_RES0_OFS 8'h10
`define SAS_STAT_OFS 8'h14
`define SAS_MASK_OFS 8'h18
`define SAS_CNT_OFS 8'h1c
`define SAS_CTRL_RST 8'h00
`define SAS_MODE_HI 7
`define SAS_MODE_LO 6
`define SAS_ACNT_HI 5
`define SAS_ACNT_LO 3
`define SAS_SCNT_HI 2
`define SAS_SCNT_LO 0
`define SAS_CONV_BIT 5
`define SAS_DONE_BIT 6
`define SAS_IRQ_BITS 8'h60
`define SAS_RESP_OK 2'b00
`define SAS_RESP_ERR 2'b10
`endif

// file: rtl/sas_pkg.sv
// Purpose: types shared by the accumulate/shift block
// Assumes: constants come from sas_params.svh
// Notes: request and answer travel as packed structs
`include "sas_params.svh"
package sas_pkg;
   typedef enum logic [1:0] {
      SAS_MODE_NONE = 2'b00,
      SAS_MODE_ACC = 2'b01,
      SAS_MODE_SHIFT = 2'b10,
      SAS_MODE_ACC_SHIFT = 2'b11
   } sas_mode_t;
   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_ACCUM = 2'b01,
      SAS_SHIFT = 2'b10,
      SAS_DONE = 2'b11
   } sas_state_t;
   typedef struct packed {
      logic valid;
      logic [`SAS_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } sas_wr_req_t;
   typedef struct packed {
      logic [31:0] data;
      logic err;
   } sas_rd_resp_t;
endpackage : sas_pkg

// file: rtl/sas_shifter.sv
// Purpose: arithmetic right shift of the running sum
// Assumes: shift code n divides by 2^(n+1)
// Notes: pure combinational, sign bit replicated
`timescale 1ns/1ps
module sas_shifter #(
   parameter int ACC_W = 32
) (
   // operand
   input wire logic [ACC_W-1:0] sum_i,
   input wire logic [2:0] code_i,
   // result
   output logic [ACC_W-1:0] res_o
);
   logic [3:0] amt;
   assign amt = {1'b0, code_i} + 4'h1;
   assign res_o = ACC_W'($signed(sum_i) >>> amt); // RULE_10
endmodule : sas_shifter

// file: rtl/sas_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the accumulate/shift registers
// Assumes: one write and one read in flight at most
// Notes: address and data of a write are taken in either order
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_axil_slave
   import sas_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // write channels
   input wire logic [`SAS_ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // read channels
   input wire logic [`SAS_ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // register side
   output sas_wr_req_t wr_o,
   input wire logic wr_err_i,
   input wire sas_rd_resp_t rd_i
);
   logic [`SAS_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic fire;
   // ready low means the channel holds a taken item
   assign fire = !awready_o && !wready_o && !bvalid_o;
   assign wr_o = '{valid: fire, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         awready_o <= 1'b1;
         wready_o <= 1'b1;
         bvalid_o <= 1'b0;
         bresp_o <= `SAS_RESP_OK;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (awvalid_i && awready_o) begin
            awready_o <= 1'b0;
            awaddr_r <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            wready_o <= 1'b0;
            wdata_r <= wdata_i;
            wstrb_r <= wstrb_i;
         end
         if (fire) begin
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            bvalid_o <= 1'b1;
            bresp_o <= wr_err_i ? `SAS_RESP_ERR : `SAS_RESP_OK;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arready_o <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rresp_o <= `SAS_RESP_OK;
      end else if (arvalid_i && arready_o) begin
         arready_o <= 1'b0;
         rvalid_o <= 1'b1;
         rdata_o <= rd_i.data;
         rresp_o <= rd_i.err ? `SAS_RESP_ERR : `SAS_RESP_OK;
      end else if (rvalid_o && rready_i) begin
         rvalid_o <= 1'b0;
         arready_o <= 1'b1;
      end
   end
endmodule : sas_axil_slave

// file: rtl/sas_accum_shift.sv
// Purpose: accumulate converter samples into a 32-bit sum, optionally averaged
// Assumes: samples arrive as one-cycle strobes on clk_i from the converter path
// Notes: software clears the sum with a zero control write before each cycle
// Notes on behaviour
// (RULE_01) four modes: none, accumulate, shift, accumulate then shift; none after reset
// (RULE_02) accumulate count 2 to 256 samples, chosen by a three-bit code
// (RULE_03) shift code picks division by 2 up to 256
// (RULE_04) 32-bit sum read as four byte registers, high byte first
// (RULE_05) bytes show partial sum during a cycle, shifted result afterwards
// (RULE_06) internal sample count steps by one per received sample
// (RULE_07) no overflow check; 256 full-scale samples fit in 32 bits
// (RULE_08) mode, accumulate count, shift count share one readable control register
// (RULE_09) zero written to control clears the sum; software does it per cycle
// (RULE_10) shift is arithmetic right, giving the average; a sum with bit 31 set comes out sign-filled instead
// (RULE_11) one sample per completed conversion, taken in order
// (RULE_12) done flag in shared status, separate from conversion flag, cleared by write
// (RULE_13) at the programmed count stop, shift if asked, then raise done
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_accum_shift
   import sas_pkg::*;
#(
   parameter int SAMPLE_W = 24,
   parameter int ACC_W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // converter result path
   input wire logic [SAMPLE_W-1:0] sample_i,
   input wire logic sample_valid_i,
   // axi4-lite write
   input wire logic [`SAS_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [`SAS_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // interrupt
   output logic irq_o
);
   localparam int MAX_CNT = 256;
   // irq trails the done event by the status flop and then the irq flop
   localparam int IRQ_LAG = 2;

   // the byte registers map exactly 32 bits; 256 samples must fit without a carry
   if (SAMPLE_W + 8 > ACC_W || ACC_W != 32) begin : g_bad_width
      $error("sas_accum_shift: sum must be 32 bits and hold 256 samples");
   end

   logic [7:0] ctrl_r;
   logic [ACC_W-1:0] acc_r;
   logic [8:0] cnt_r;
   logic [7:0] status_r;
   logic [7:0] mask_r;
   sas_state_t state_r;
   sas_wr_req_t wr;
   sas_rd_resp_t rd;
   logic wr_err;
   logic [ACC_W-1:0] shifted;

   // register decode shared by read and write paths
   function automatic logic addr_ok(input logic [`SAS_ADDR_W-1:0] a);
      return a == `SAS_CTRL_OFS || a == `SAS_RES3_OFS || a == `SAS_RES2_OFS ||
             a == `SAS_RES1_OFS || a == `SAS_RES0_OFS || a == `SAS_STAT_OFS ||
             a == `SAS_MASK_OFS || a == `SAS_CNT_OFS;
   endfunction : addr_ok

   // samples to take: one in shift-only mode, 2^(code+1) otherwise
   function automatic logic [8:0] target(input logic [7:0] c);
      logic [3:0] amt;
      amt = {1'b0, c[`SAS_ACNT_HI:`SAS_ACNT_LO]} + 4'h1;
      if (sas_mode_t'(c[`SAS_MODE_HI:`SAS_MODE_LO]) == SAS_MODE_SHIFT) begin
         return 9'h001;
      end
      return 9'h001 << amt; // RULE_02
   endfunction : target

   function automatic logic wr_hit(input sas_wr_req_t w, input logic [`SAS_ADDR_W-1:0] a);
      return w.valid && w.addr == a && w.strb[0];
   endfunction : wr_hit

   sas_axil_slave u_bus (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .awaddr_i(s_axi_awaddr_i),
      .awvalid_i(s_axi_awvalid_i),
      .awready_o(s_axi_awready_o),
      .wdata_i(s_axi_wdata_i),
      .wstrb_i(s_axi_wstrb_i),
      .wvalid_i(s_axi_wvalid_i),
      .wready_o(s_axi_wready_o),
      .bresp_o(s_axi_bresp_o),
      .bvalid_o(s_axi_bvalid_o),
      .bready_i(s_axi_bready_i),
      .araddr_i(s_axi_araddr_i),
      .arvalid_i(s_axi_arvalid_i),
      .arready_o(s_axi_arready_o),
      .rdata_o(s_axi_rdata_o),
      .rresp_o(s_axi_rresp_o),
      .rvalid_o(s_axi_rvalid_o),
      .rready_i(s_axi_rready_i),
      .wr_o(wr),
      .wr_err_i(wr_err),
      .rd_i(rd)
   );

   sas_shifter #(
      .ACC_W(ACC_W)
   ) u_shift (
      .sum_i(acc_r),
      .code_i(ctrl_r[`SAS_SCNT_HI:`SAS_SCNT_LO]),
      .res_o(shifted)
   );

   logic wr_ctrl;
   logic ctrl_zero;
   sas_mode_t mode;
   logic has_shift;
   logic take;
   logic last;
   logic done_evt;
   logic [ACC_W-1:0] sample_ext;

   assign wr_err = !addr_ok(wr.addr);
   assign wr_ctrl = wr_hit(wr, `SAS_CTRL_OFS);
   assign ctrl_zero = wr.data[7:0] == 8'h00;
   assign mode = sas_mode_t'(ctrl_r[`SAS_MODE_HI:`SAS_MODE_LO]);
   assign has_shift = mode == SAS_MODE_SHIFT || mode == SAS_MODE_ACC_SHIFT;
   assign sample_ext = ACC_W'(sample_i);
   // a control write in the same cycle wins over an arriving sample
   assign take = state_r == SAS_ACCUM && sample_valid_i && !wr_ctrl; // RULE_11
   assign last = take && (cnt_r + 9'h001 == target(ctrl_r)); // RULE_13
   assign done_evt = (last && !has_shift) || (state_r == SAS_SHIFT && !wr_ctrl); // RULE_13

   // control register, read back whole
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= `SAS_CTRL_RST; // RULE_01
      end else if (wr_ctrl) begin
         ctrl_r <= wr.data[7:0]; // RULE_08
      end
   end

   // sequencing of one accumulation cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= SAS_IDLE;
      end else if (wr_ctrl) begin
         if (wr.data[`SAS_MODE_HI:`SAS_MODE_LO] == SAS_MODE_NONE) begin
            state_r <= SAS_IDLE; // RULE_01
         end else begin
            state_r <= SAS_ACCUM;
         end
      end else begin
         unique case (state_r)
            SAS_IDLE: state_r <= SAS_IDLE;
            SAS_ACCUM: begin
               if (last) begin
                  state_r <= has_shift ? SAS_SHIFT : SAS_DONE; // RULE_13
               end
            end
            SAS_SHIFT: state_r <= SAS_DONE;
            SAS_DONE: state_r <= SAS_DONE;
         endcase
      end
   end

   // running sum; cleared only by reset or by a zero control write
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_r <= '0;
      end else if (wr_ctrl && ctrl_zero) begin
         acc_r <= '0; // RULE_09
      end else if (take && mode == SAS_MODE_SHIFT) begin
         acc_r <= sample_ext;
      end else if (take) begin
         acc_r <= acc_r + sample_ext; // RULE_05 RULE_07
      end else if (state_r == SAS_SHIFT && !wr_ctrl) begin
         acc_r <= shifted; // RULE_03 RULE_05
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= '0;
      end else if (wr_ctrl) begin
         cnt_r <= '0;
      end else if (take) begin
         cnt_r <= cnt_r + 9'h001; // RULE_06
      end
   end

   // sticky flags, write one to clear; a same-cycle event wins
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_r <= '0;
      end else begin
         logic [7:0] clr;
         logic [7:0] evt;
         clr = wr_hit(wr, `SAS_STAT_OFS) ? wr.data[7:0] : 8'h00;
         evt = '0;
         evt[`SAS_CONV_BIT] = sample_valid_i;
         evt[`SAS_DONE_BIT] = done_evt; // RULE_12
         status_r <= ((status_r & ~clr) | evt) & `SAS_IRQ_BITS; // RULE_12
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_r <= '0;
      end else if (wr_hit(wr, `SAS_MASK_OFS)) begin
         mask_r <= wr.data[7:0] & `SAS_IRQ_BITS;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_r & mask_r);
      end
   end

   // read mux; the slave registers it on the address handshake
   always_comb begin
      rd.err = !addr_ok(s_axi_araddr_i);
      rd.data = 32'h0000_0000;
      unique case (s_axi_araddr_i)
         `SAS_CTRL_OFS: rd.data = {24'h00_0000, ctrl_r};
         `SAS_RES3_OFS: rd.data = {24'h00_0000, acc_r[31:24]}; // RULE_04
         `SAS_RES2_OFS: rd.data = {24'h00_0000, acc_r[23:16]}; // RULE_04
         `SAS_RES1_OFS: rd.data = {24'h00_0000, acc_r[15:8]}; // RULE_04
         `SAS_RES0_OFS: rd.data = {24'h00_0000, acc_r[7:0]}; // RULE_04
         `SAS_STAT_OFS: rd.data = {24'h00_0000, status_r};
         `SAS_MASK_OFS: rd.data = {24'h00_0000, mask_r};
         `SAS_CNT_OFS: rd.data = {23'h00_0000, cnt_r};
         default: rd.data = 32'h0000_0000;
      endcase
   end

   // checks
   logic [ACC_W:0] sum_wide;
   logic [ACC_W:0] fill_bound;
   assign sum_wide = {1'b0, acc_r} + {1'b0, sample_ext};
   // largest sum that the samples taken so far can have built
   assign fill_bound = {1'b0, ACC_W'(cnt_r)} * {1'b0, ACC_W'({SAMPLE_W{1'b1}})};

   sequence s_last_sample;
      last && mode == SAS_MODE_ACC_SHIFT;
   endsequence
   sequence s_shift_then_done;
      ##1 (state_r == SAS_SHIFT && !wr_ctrl)
      ##1 (state_r == SAS_DONE && status_r[`SAS_DONE_BIT]);
   endsequence
   // a write answers one cycle after both items are held; a read one cycle after it is taken
   sequence s_write_held;
      !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   endsequence
   sequence s_write_answered;
      s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   sequence s_read_answered;
      s_axi_rvalid_o && !s_axi_arready_o;
   endsequence

   chk_mode_none_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_01
      mode == SAS_MODE_NONE |-> state_r == SAS_IDLE)
      else $error("mode none but block not idle");
   chk_count_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_02
      state_r == SAS_ACCUM |-> cnt_r < target(ctrl_r) && target(ctrl_r) <= 9'(MAX_CNT))
      else $error("sample count beyond programmed count");
   chk_shift_divide: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_03
      state_r == SAS_SHIFT && !wr_ctrl |=>
      acc_r == ACC_W'($signed($past(acc_r)) >>>
      ({1'b0, $past(ctrl_r[`SAS_SCNT_HI:`SAS_SCNT_LO])} + 4'd1)))
      else $error("shift result does not match shift code");
   chk_byte_read: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_04
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `SAS_RES3_OFS |=>
      s_axi_rvalid_o && s_axi_rdata_o == {24'h00_0000, $past(acc_r[31:24])})
      else $error("top result byte read wrong");
   chk_partial_sum: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_05
      take && mode != SAS_MODE_SHIFT |=> acc_r == $past(acc_r) + ACC_W'($past(sample_i)))
      else $error("partial sum not updated by sample");
   chk_count_step: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_06
      take |=> cnt_r == $past(cnt_r) + 9'h001)
      else $error("sample count did not step by one");
   chk_no_carry: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
      take && mode != SAS_MODE_SHIFT && {1'b0, acc_r} <= fill_bound |-> !sum_wide[ACC_W])
      else $error("accumulator carried out");
   chk_ctrl_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_08
      wr_ctrl |=> ctrl_r == $past(wr.data[7:0]))
      else $error("control register did not take written value");
   chk_zero_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_09
      wr_ctrl && ctrl_zero |=> acc_r == '0 && cnt_r == 9'h000 && state_r == SAS_IDLE)
      else $error("zero control write did not clear sum");
   chk_sign_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_10
      state_r == SAS_SHIFT && !wr_ctrl |=> acc_r[ACC_W-1] == $past(acc_r[ACC_W-1]))
      else $error("shift lost the sign bit");
   chk_conv_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_11
      sample_valid_i |=> status_r[`SAS_CONV_BIT])
      else $error("conversion flag not set by sample");
   chk_done_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
      done_evt && mask_r[`SAS_DONE_BIT] && !wr.valid |-> ##[1:IRQ_LAG] irq_o)
      else $error("done flag did not raise interrupt");
   chk_done_order: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_13
      s_last_sample |-> s_shift_then_done)
      else $error("shift and done did not follow last sample");
   chk_write_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_08
      s_write_held |=> s_write_answered)
      else $error("write response not raised after both items held");
   chk_read_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_04
      s_read_taken |=> s_read_answered)
      else $error("read data not raised after address taken");
   chk_shift_load: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_01
      take && mode == SAS_MODE_SHIFT |=> acc_r == $past(sample_ext))
      else $error("shift-only mode did not load the sample");
   chk_done_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_13
      state_r == SAS_DONE && !wr_ctrl |=> $stable(acc_r) && $stable(cnt_r))
      else $error("sum moved after done");
   chk_irq_level: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
      irq_o == |($past(status_r) & $past(mask_r)))
      else $error("interrupt does not follow unmasked flags");
   chk_flag_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
      wr_hit(wr, `SAS_STAT_OFS) && wr.data[`SAS_DONE_BIT] && !done_evt |=>
      !status_r[`SAS_DONE_BIT])
      else $error("done flag not cleared by write");
endmodule : sas_accum_shift

// file: verif/sas_adc_model.sv
// Purpose: converter result path model that feeds samples to the block
// Assumes: one result per completed conversion, a pulse of one clk_i cycle
// Notes: between pulses the bus shows the inverted last value, never stale data
`timescale 1ns/1ps
module sas_adc_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // result path
   output logic [23:0] sample_o,
   output logic sample_valid_o
);
   initial begin
      sample_o = 24'h000000;
      sample_valid_o = 1'b0;
   end
   // n conversions, gap idle cycles apart; gap 0 gives back-to-back results
   task automatic send_burst(input logic [23:0] base, input logic [23:0] step,
                             input int n, input int gap);
      logic [23:0] v;
      v = base;
      // no conversion results leave the converter while the block is held in reset
      wait (reset_n_i === 1'b1);
      for (int i = 0; i < n; i++) begin
         sample_o <= v;
         sample_valid_o <= 1'b1;
         @(posedge clk_i);
         if (gap > 0) begin
            sample_o <= ~v;
            sample_valid_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
         end
         v = v + step;
      end
      sample_o <= ~(v - step);
      sample_valid_o <= 1'b0;
   endtask : send_burst
endmodule : sas_adc_model

// file: verif/testbench.sv
// Purpose: self-checking bench of the accumulate/shift block over its register bus
// Assumes: samples come from sas_adc_model, one at a time
// Notes: expectations are worked out here from the mode and count codes
`timescale 1ns/1ps
`include "sas_params.svh"
`define CHECK_EQ(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   localparam logic [1:0] rok = `SAS_RESP_OK;
   localparam logic [1:0] rerr = `SAS_RESP_ERR;
   logic clk_i, reset_n_i;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [23:0] sample;
   logic sample_valid;
   logic [31:0] s;
   int bad_count, total_checks;

   sas_adc_model sas_adc_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .sample_o(sample), .sample_valid_o(sample_valid));
   sas_accum_shift sas_accum_shift_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .sample_i(sample), .sample_valid_i(sample_valid),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   // bready rises only once both items are taken, so no signal is set twice per step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_i);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin @(posedge clk_i); end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHECK_EQ(bresp, er)
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin @(posedge clk_i); end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin @(posedge clk_i); end while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHECK_EQ(rdata, e)
      `CHECK_EQ(rresp, er)
   endtask : rd

   task automatic rd_sum(input logic [31:0] e);
      rd(`SAS_RES3_OFS, {24'h000000, e[31:24]}, rok);
      rd(`SAS_RES2_OFS, {24'h000000, e[23:16]}, rok);
      rd(`SAS_RES1_OFS, {24'h000000, e[15:8]}, rok);
      rd(`SAS_RES0_OFS, {24'h000000, e[7:0]}, rok);
   endtask : rd_sum

   // status cleared first so that a stale done flag cannot satisfy the wait
   task automatic start_cycle(input logic [7:0] c);
      wr(`SAS_STAT_OFS, 32'h00000060, rok);
      wr(`SAS_CTRL_OFS, 32'h00000000, rok);
      wr(`SAS_CTRL_OFS, {24'h000000, c}, rok);
   endtask : start_cycle

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      `CHECK_EQ(irq, 1'b1)
   endtask : wait_irq

   initial begin
      reset_n_i = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      bad_count = 0;
      total_checks = 0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd(`SAS_CTRL_OFS, 32'h00000000, rok);
      rd_sum(32'h00000000);
      rd(`SAS_STAT_OFS, 32'h00000000, rok);
      rd(8'h40, 32'h00000000, rerr);
      wr(8'h40, 32'h0000005a, rerr);
      $display("test reset_and_map done");
      wr(`SAS_MASK_OFS, 32'h00000040, rok);
      for (int n = 0; n < 8; n++) begin
         start_cycle({2'b01, 3'(n), 3'b000});
         sas_adc_model_i.send_burst(24'hffffff, 24'h000000, 1 << (n + 1), 1);
         wait_irq();
         rd(`SAS_CNT_OFS, 32'h1 << (n + 1), rok);
         rd_sum((32'h1 << (n + 1)) * 32'h00ffffff);
      end
      sas_adc_model_i.send_burst(24'h000001, 24'h000000, 2, 1);
      rd_sum(32'hffffff00);
      rd(`SAS_STAT_OFS, 32'h00000060, rok);
      wr(`SAS_CTRL_OFS, 32'h00000000, rok);
      rd_sum(32'h00000000);
      $display("test accumulate_counts done");
      wr(`SAS_MASK_OFS, 32'h00000000, rok);
      repeat (2) @(posedge clk_i);
      `CHECK_EQ(irq, 1'b0)
      wr(`SAS_STAT_OFS, 32'h00000020, rok);
      rd(`SAS_STAT_OFS, 32'h00000040, rok);
      wr(`SAS_MASK_OFS, 32'h00000040, rok);
      repeat (2) @(posedge clk_i);
      `CHECK_EQ(irq, 1'b1)
      $display("test flags done");
      for (int n = 0; n < 8; n++) begin
         start_cycle({2'b10, 3'b000, 3'(n)});
         sas_adc_model_i.send_burst(24'hffffff, 24'h000000, 1, 0);
         wait_irq();
         rd_sum(32'h00ffffff >> (n + 1));
      end
      $display("test shift_codes done");
      start_cycle(8'hd2);
      rd(`SAS_CTRL_OFS, 32'h000000d2, rok);
      sas_adc_model_i.send_burst(24'h100000, 24'h010101, 5, 0);
      rd(`SAS_CNT_OFS, 32'h00000005, rok);
      rd_sum(32'h005a0a0a);
      sas_adc_model_i.send_burst(24'h150505, 24'h010101, 3, 0);
      wait_irq();
      s = 32'h0;
      for (int i = 0; i < 8; i++) s = s + 32'h100000 + 32'h010101 * i;
      rd_sum(s >> 3);
      start_cycle(8'hf8);
      sas_adc_model_i.send_burst(24'hffffff, 24'h000000, 256, 0);
      wait_irq();
      rd_sum(32'hffffff80);
      $display("test accumulate_shift done");
      start_cycle(8'h02);
      sas_adc_model_i.send_burst(24'h123456, 24'h000001, 4, 1);
      repeat (4) @(posedge clk_i);
      rd_sum(32'h00000000);
      `CHECK_EQ(irq, 1'b0)
      $display("test no_source done");
      end_of_test();
   end

   initial begin
      #(25 * 30000);
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
   end
endmodule : testbench
